// ### cec_pkg.sv
// constants shared by the comparator event control block
package cec_pkg;
	// ============================================================
	// register byte offsets
	localparam logic [3:0] CEC_OFS_CTRL = 4'h0;
	localparam logic [3:0] CEC_OFS_STATUS = 4'h4;
	localparam logic [3:0] CEC_OFS_MASK = 4'h8;
	// register index codes produced by the decoder
	localparam logic [1:0] CEC_IDX_CTRL = 2'h0;
	localparam logic [1:0] CEC_IDX_STATUS = 2'h1;
	localparam logic [1:0] CEC_IDX_MASK = 2'h2;
	localparam logic [1:0] CEC_IDX_NONE = 2'h3;
	// ============================================================
	// control register field positions
	localparam int CEC_BIT_OE = 14;
	localparam int CEC_BIT_INV = 13;
	localparam int CEC_BIT_AMP = 10;
	localparam int CEC_BIT_EVT = 9;
	localparam int CEC_BIT_RES = 8;
	localparam int CEC_BIT_EDGE = 6;
	localparam int CEC_BIT_REF = 4;
	localparam int CEC_BIT_CHAN = 0;
	// implemented bits of the control word; the rest read zero
	localparam logic [15:0] CEC_CTRL_RMASK = 16'h67d3;
	localparam logic [15:0] CEC_CTRL_RESET = 16'h0000;
	// ============================================================
	// event edge select codes
	localparam logic [1:0] CEC_EDGE_OFF = 2'h0;
	localparam logic [1:0] CEC_EDGE_RISE = 2'h1;
	localparam logic [1:0] CEC_EDGE_FALL = 2'h2;
	localparam logic [1:0] CEC_EDGE_ANY = 2'h3;
	// ============================================================
	// interrupt status bits
	localparam int CEC_IRQ_W = 2;
	localparam int CEC_IRQ_EVENT = 0;
	localparam int CEC_IRQ_CHANGE = 1;
	localparam logic [CEC_IRQ_W-1:0] CEC_IRQ_RESET = 2'h0;
	// axi response codes
	localparam logic [1:0] CEC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CEC_RESP_SLVERR = 2'h2;
endpackage : cec_pkg

// ### cec_cells.sv
// two-stage synchroniser and edge detector used by the control block
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// level synchroniser
module cec_sync
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// asynchronous level in, synchronised level out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : cec_sync

// ============================================================
// edge detector on an already synchronised level
module cec_edge
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// level in, previous level and edge strobes out
	input wire logic level,
	output logic level_q,
	output logic rise,
	output logic fall
);
	// previous sample of the level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			level_q <= 1'b0;
		else
			level_q <= level;
	end

	// strobes compare the present level with the stored one
	assign rise = level & ~level_q;
	assign fall = ~level & level_q;
endmodule : cec_edge

`default_nettype wire

// ### cec_top.sv
// comparator event control block with an axi4-lite register slave
//
// Overview of operation
// (RULE1) polarity bit set inverts the raw result
// (RULE2) amplifier enable bit drives amplifier on/off
// (RULE3) selected edge sets sticky flag, blocks retrigger
// (RULE4) result bit reads the polarity-adjusted comparison
// (RULE5) edge code 11 triggers on any change
// (RULE6) edge code 10 triggers on falling adjusted
// (RULE7) edge code 01 triggers on rising adjusted
// (RULE8) edge code 00 generates no trigger
// (RULE9) reference bit picks internal reference or pin
// (RULE10) channel code picks one of four negatives
// (RULE11) absent selected inputs are tied to ground
// (RULE12) unimplemented bits read zero, ignore writes
// (RULE13) amplifier enable leaves comparator path working
// (RULE14) software clears flags before enabling interrupt
// (RULE15) output enable drives result onto pin
// (RULE16) raw result synchronised through two flops
`timescale 1ns/1ps
`default_nettype none

module cec_top
#(
	parameter int ADDR_W = 4,
	// inputs bonded out: bit 4 positive pin, bits 3..0 negative pins
	parameter logic [4:0] INPUT_PRESENT = 5'h1f
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog core
	input wire logic comp_raw,
	output logic amplifier_enable,
	output logic positive_reference_select,
	output logic positive_pin_connect,
	output logic positive_ground_tie,
	output logic [3:0] negative_pin_connect,
	output logic negative_ground_tie,
	// result pin
	output logic result_output_pin,
	output logic result_output_pin_oe,
	// events
	output logic compare_trigger,
	output logic sticky_event_flag,
	output logic irq
);
	import cec_pkg::*;

	// ============================================================
	// address decode shared by both channels
	function automatic logic [1:0] cec_reg_idx(input logic [ADDR_W-1:0] addr);
		logic [1:0] idx;
		idx = CEC_IDX_NONE;
		if (addr[ADDR_W-1:2] == CEC_OFS_CTRL[3:2])
			idx = CEC_IDX_CTRL;
		else if (addr[ADDR_W-1:2] == CEC_OFS_STATUS[3:2])
			idx = CEC_IDX_STATUS;
		else if (addr[ADDR_W-1:2] == CEC_OFS_MASK[3:2])
			idx = CEC_IDX_MASK;
		return idx;
	endfunction : cec_reg_idx

	// ============================================================
	// signals
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic wr_ctrl_hi;
	logic wr_ctrl_lo;
	logic [1:0] wr_idx;
	logic oe_q;
	logic invert_q;
	logic amp_en_q;
	logic event_q;
	logic [1:0] edge_sel_q;
	logic ref_sel_q;
	logic [1:0] chan_sel_q;
	logic [CEC_IRQ_W-1:0] status_q;
	logic [CEC_IRQ_W-1:0] mask_q;
	logic [CEC_IRQ_W-1:0] status_set;
	logic sync_lvl;
	logic adjusted;
	logic cmp_lvl;
	logic rise;
	logic fall;
	logic edge_hit;
	logic trig;
	logic evt_clear;
	logic [15:0] ctrl_rd;
	logic rd_was_ctrl_q;

	// ============================================================
	// axi write channel: address and data taken in either order
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_idx = cec_reg_idx(awaddr_q);
	assign wr_ctrl_lo = do_write && wr_idx == CEC_IDX_CTRL && wstrb_q[0];
	assign wr_ctrl_hi = do_write && wr_idx == CEC_IDX_CTRL && wstrb_q[1];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CEC_RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			// response only once both halves are in
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_idx == CEC_IDX_NONE) ? CEC_RESP_SLVERR : CEC_RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ============================================================
	// control fields; unlisted bits have no storage at all
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe_q <= CEC_CTRL_RESET[CEC_BIT_OE];
			invert_q <= CEC_CTRL_RESET[CEC_BIT_INV];
			amp_en_q <= CEC_CTRL_RESET[CEC_BIT_AMP];
			edge_sel_q <= CEC_CTRL_RESET[CEC_BIT_EDGE +: 2];
			ref_sel_q <= CEC_CTRL_RESET[CEC_BIT_REF];
			chan_sel_q <= CEC_CTRL_RESET[CEC_BIT_CHAN +: 2];
		end
		else
		begin
			if (wr_ctrl_hi)
			begin
				oe_q <= wdata_q[CEC_BIT_OE];
				invert_q <= wdata_q[CEC_BIT_INV];
				amp_en_q <= wdata_q[CEC_BIT_AMP]; // [RULE2]
			end
			if (wr_ctrl_lo)
			begin
				edge_sel_q <= wdata_q[CEC_BIT_EDGE +: 2];
				ref_sel_q <= wdata_q[CEC_BIT_REF];
				chan_sel_q <= wdata_q[CEC_BIT_CHAN +: 2];
			end
		end
	end

	// ============================================================
	// comparator path: synchronise, adjust polarity, find edges
	cec_sync u_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(comp_raw), // [RULE16]
		.sync_out(sync_lvl)
	);

	// the path never looks at the amplifier enable [RULE13]
	assign adjusted = sync_lvl ^ invert_q; // [RULE1]

	cec_edge u_edge
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.level(adjusted),
		.level_q(cmp_lvl),
		.rise(rise),
		.fall(fall)
	);

	// edge select; a toggle of the polarity bit counts as a change too
	always_comb
	begin
		unique case (edge_sel_q)
			CEC_EDGE_ANY: edge_hit = rise | fall; // [RULE5]
			CEC_EDGE_FALL: edge_hit = fall; // [RULE6]
			CEC_EDGE_RISE: edge_hit = rise; // [RULE7]
			default: edge_hit = 1'b0; // [RULE8]
		endcase
	end

	// a set flag masks every later trigger
	assign trig = edge_hit && !event_q; // [RULE3]
	// flag clears by writing zero to it; a write of one is ignored
	assign evt_clear = wr_ctrl_hi && !wdata_q[CEC_BIT_EVT];

	// ============================================================
	// sticky event flag; a new event beats a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			event_q <= CEC_CTRL_RESET[CEC_BIT_EVT];
		else if (trig)
			event_q <= 1'b1; // [RULE3]
		else if (evt_clear)
			event_q <= 1'b0;
	end

	// ============================================================
	// interrupt status, write one to clear, set wins; mask written directly
	assign status_set[CEC_IRQ_EVENT] = trig;
	assign status_set[CEC_IRQ_CHANGE] = rise | fall;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_q <= CEC_IRQ_RESET;
			mask_q <= CEC_IRQ_RESET;
		end
		else
		begin
			if (do_write && wr_idx == CEC_IDX_STATUS && wstrb_q[0])
				status_q <= (status_q & ~wdata_q[CEC_IRQ_W-1:0]) | status_set;
			else
				status_q <= status_q | status_set;
			if (do_write && wr_idx == CEC_IDX_MASK && wstrb_q[0])
				mask_q <= wdata_q[CEC_IRQ_W-1:0];
		end
	end

	// ============================================================
	// read channel, one cycle from address to data
	always_comb
	begin
		ctrl_rd = 16'h0000; // [RULE12]
		ctrl_rd[CEC_BIT_OE] = oe_q;
		ctrl_rd[CEC_BIT_INV] = invert_q;
		ctrl_rd[CEC_BIT_AMP] = amp_en_q;
		ctrl_rd[CEC_BIT_EVT] = event_q;
		ctrl_rd[CEC_BIT_RES] = cmp_lvl; // [RULE4]
		ctrl_rd[CEC_BIT_EDGE +: 2] = edge_sel_q;
		ctrl_rd[CEC_BIT_REF] = ref_sel_q;
		ctrl_rd[CEC_BIT_CHAN +: 2] = chan_sel_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CEC_RESP_OKAY;
			rd_was_ctrl_q <= 1'b0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= CEC_RESP_OKAY;
			rd_was_ctrl_q <= cec_reg_idx(s_axi_araddr) == CEC_IDX_CTRL;
			unique case (cec_reg_idx(s_axi_araddr))
				CEC_IDX_CTRL: s_axi_rdata <= {16'h0000, ctrl_rd & CEC_CTRL_RMASK}; // [RULE12]
				CEC_IDX_STATUS: s_axi_rdata <= {30'h0, status_q};
				CEC_IDX_MASK: s_axi_rdata <= {30'h0, mask_q};
				CEC_IDX_NONE:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= CEC_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ============================================================
	// registered outputs to the analog core, pins and interrupt
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			amplifier_enable <= 1'b0;
			positive_reference_select <= 1'b0;
			positive_pin_connect <= 1'b0;
			positive_ground_tie <= 1'b0;
			negative_pin_connect <= 4'h0;
			negative_ground_tie <= 1'b0;
			result_output_pin <= 1'b0;
			result_output_pin_oe <= 1'b0;
			compare_trigger <= 1'b0;
			sticky_event_flag <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			amplifier_enable <= amp_en_q; // [RULE2]
			positive_reference_select <= ref_sel_q; // [RULE9]
			// a missing pin is grounded instead of left floating
			positive_pin_connect <= !ref_sel_q && INPUT_PRESENT[4]; // [RULE9]
			positive_ground_tie <= !ref_sel_q && !INPUT_PRESENT[4]; // [RULE11]
			negative_pin_connect <= (4'h1 << chan_sel_q) & INPUT_PRESENT[3:0]; // [RULE10]
			negative_ground_tie <= !INPUT_PRESENT[chan_sel_q]; // [RULE11]
			result_output_pin <= oe_q & cmp_lvl; // [RULE15]
			result_output_pin_oe <= oe_q; // [RULE15]
			compare_trigger <= trig;
			sticky_event_flag <= event_q;
			irq <= |(status_q & mask_q);
		end
	end

	// ============================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_invert_path: assert property (cmp_lvl == $past(sync_lvl ^ invert_q)) // [RULE1]
		else $error("adjusted level does not follow raw xor polarity");
	chk_amp_follow: assert property (wr_ctrl_hi |-> ##2 amplifier_enable == $past(wdata_q[CEC_BIT_AMP], 2)) // [RULE2]
		else $error("amplifier enable did not follow control write");
	chk_event_hold: assert property (event_q && !evt_clear |=> event_q) // [RULE3]
		else $error("event flag dropped without a clear");
	chk_no_retrigger: assert property (event_q |-> !trig ##1 !compare_trigger) // [RULE3]
		else $error("trigger while event flag set");
	chk_edge_any: assert property (edge_sel_q == CEC_EDGE_ANY && !event_q && adjusted != cmp_lvl |=> event_q && compare_trigger) // [RULE5]
		else $error("change missed in any-edge mode");
	chk_edge_fall: assert property (trig && edge_sel_q == CEC_EDGE_FALL |-> !adjusted && cmp_lvl) // [RULE6]
		else $error("falling mode fired on a non-falling edge");
	chk_edge_rise: assert property (trig && edge_sel_q == CEC_EDGE_RISE |-> adjusted && !cmp_lvl) // [RULE7]
		else $error("rising mode fired on a non-rising edge");
	chk_edge_off: assert property (edge_sel_q == CEC_EDGE_OFF |-> !trig) // [RULE8]
		else $error("trigger with edge detection disabled");
	chk_ground_tie: assert property (negative_ground_tie |-> negative_pin_connect == 4'h0) // [RULE11]
		else $error("absent negative input both tied and connected");
	chk_reserved_zero: assert property (s_axi_rvalid && rd_was_ctrl_q |-> (s_axi_rdata & ~{16'h0000, CEC_CTRL_RMASK}) == 32'h0000_0000) // [RULE12]
		else $error("unimplemented control bits read nonzero");
	chk_pin_enable: assert property (!result_output_pin_oe |-> !result_output_pin) // [RULE15]
		else $error("result pin driven while output disabled");

	cov_any_edge: cover property (trig && edge_sel_q == CEC_EDGE_ANY);
	cov_event_clear: cover property (event_q ##[1:50] !event_q);
	cov_irq_raise: cover property ($rose(irq));
	cov_set_beats_clear: cover property (trig && evt_clear);
endmodule : cec_top

`default_nettype wire

// ### cec_core_model.sv
// behavioural analog core and shared interrupt flag beside the control block
`timescale 1ns/1ps
`default_nettype none

module cec_core_model
(
	// clock
	input wire logic aclk,
	// pin levels set by the bench
	input wire logic [7:0] pos_level,
	input wire logic [7:0] neg_level,
	// routing and trigger from the block, shared flag clear from the bench
	input wire logic positive_reference_select,
	input wire logic positive_pin_connect,
	input wire logic [3:0] negative_pin_connect,
	input wire logic compare_trigger,
	input wire logic shared_flag_clear,
	// raw result and shared flag
	output logic comp_raw,
	output logic shared_compare_irq_flag
);
	logic [7:0] vin_p;
	logic [7:0] vin_n;

	// ============================================================
	// input routing
	// reference follows pos_level so both sources give the same sense
	assign vin_p = (positive_reference_select || positive_pin_connect) ? pos_level : 8'h00;
	assign vin_n = (|negative_pin_connect) ? neg_level : 8'h00;

	// raw result lands off the clock edge, as an analog output would
	always @(vin_p or vin_n)
		comp_raw <= #3 (vin_p > vin_n);

	// shared flag: set by a trigger, cleared only by software
	always @(posedge aclk)
		if (shared_flag_clear)
			shared_compare_irq_flag <= 1'b0;
		else if (compare_trigger)
			shared_compare_irq_flag <= 1'b1;
endmodule : cec_core_model

`default_nettype wire

// ### comparator_event_control_test.sv
// self-checking bench for the comparator event control block
`timescale 1ns/1ps
`default_nettype none

module comparator_event_control_test;
	import cec_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb, nconn;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic raw, amp, rsel, pconn, pgnd, ngnd, rpin, roe, trig, evt, irq, sflag, sclr;
	logic [7:0] pos_level, neg_level;
	int fail_count, tests_run, trig_seen, seed, c, i, cw, flag, base;

	// absent fourth negative pin exercises the ground tie
	cec_top #(.ADDR_W(4), .INPUT_PRESENT(5'h17)) cec_top_inst
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.comp_raw(raw), .amplifier_enable(amp), .positive_reference_select(rsel),
		.positive_pin_connect(pconn), .positive_ground_tie(pgnd),
		.negative_pin_connect(nconn), .negative_ground_tie(ngnd),
		.result_output_pin(rpin), .result_output_pin_oe(roe),
		.compare_trigger(trig), .sticky_event_flag(evt), .irq(irq)
	);

	cec_core_model cec_core_model_inst
	(
		.aclk(aclk), .pos_level(pos_level), .neg_level(neg_level),
		.positive_reference_select(rsel), .positive_pin_connect(pconn),
		.negative_pin_connect(nconn), .compare_trigger(trig), .shared_flag_clear(sclr),
		.comp_raw(raw), .shared_compare_irq_flag(sflag)
	);

	// ============================================================
	// clock and trigger counter
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk)
		if (aresetn && trig === 1'b1)
			trig_seen <= trig_seen + 1;

	// ============================================================
	// reporting
	task automatic stop_test;
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask : cmp

	// ============================================================
	// bus tasks: handshakes sampled between edges, released after the edge
	task automatic wr(input logic [3:0] a, input logic [31:0] dd, input logic [3:0] s);
		int n;
		logic aw, w, b;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		n = 0;
		while (!b && n < 50)
		begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid === 1'b1;
			r = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		if (!b)
		begin
			fail_count++;
			stop_test;
		end
	endtask : wr

	task automatic rd(input logic [3:0] a);
		int n;
		logic ar, v;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		n = 0;
		while (!v && n < 50)
		begin
			@(negedge aclk);
			ar = arvalid && arready;
			v = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		if (!v)
		begin
			fail_count++;
			stop_test;
		end
	endtask : rd

	// ============================================================
	// model checks of routing outputs and of one comparator step
	task automatic outs(input int w, input int adj);
		cmp("amp", w >> 10 & 1, amp);
		cmp("ref sel", w >> 4 & 1, rsel);
		cmp("pos pin", ~w >> 4 & 1, pconn);
		cmp("pos gnd", 0, pgnd);
		cmp("neg pins", (w & 3) == 3 ? 0 : 1 << (w & 3), nconn);
		cmp("neg gnd", (w & 3) == 3, ngnd);
		cmp("pin oe", w >> 14 & 1, roe);
		cmp("pin", (w >> 14 & 1) & adj, rpin);
	endtask : outs

	task automatic step(input int rising);
		int adj;
		int hit;
		repeat (10) @(posedge aclk);
		@(negedge aclk); // look at outputs away from the launching edge
		adj = rising ^ i;
		hit = flag == 0 && (c == 3 || (c == 1 && adj == 1) || (c == 2 && adj == 0));
		if (hit)
			flag = 1;
		cmp("triggers", flag, trig_seen - base);
		cmp("event out", flag, evt);
		cmp("irq", flag, irq);
		cmp("shared flag", flag, sflag);
		outs(cw, adj);
		rd(4'h0);
		cmp("control", cw & 32'h64d3 | flag << 9 | adj << 8, d);
		rd(4'h4);
		cmp("status", 2 | flag, d);
	endtask : step

	// ============================================================
	// main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wstrb, wdata} = 44'h0;
		pos_level = 8'h00;
		neg_level = 8'h00;
		sclr = 1'b1;
		aresetn = 1'b0;
		seed = $urandom(10);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sclr <= 1'b0;
		for (c = 0; c < 3; c++)
		begin
			rd(4 * c);
			cmp("reset word", 0, d);
		end
		wr(4'hc, 32'h1, 4'hf);
		cmp("bad wr resp", CEC_RESP_SLVERR, r);
		rd(4'hc);
		cmp("bad rd data", 0, d);
		cmp("bad rd resp", CEC_RESP_SLVERR, r);
		// all ones: inversion alone makes an adjusted edge under code 11
		base = trig_seen;
		wr(4'h0, 32'hffffffff, 4'hf);
		repeat (8) @(posedge aclk);
		@(negedge aclk); // settled outputs only
		outs(32'hffff, 1);
		cmp("inv trigger", 1, trig_seen - base);
		rd(4'h0);
		cmp("ctrl all ones", 16'h67d3, d);
		// every edge code under both polarities
		for (c = 0; c < 4; c++)
			for (i = 0; i < 2; i++)
			begin
				// random pin enable and amplifier enable, so both levels are seen
				cw = ($urandom % 2) << 14 | i << 13 | ($urandom % 2) << 10;
				cw = cw | ($urandom % 2) << 4 | $urandom % 4;
				neg_level <= 8'(1 + $urandom % 100);
				wr(4'h0, cw, 4'h3);
				repeat (6) @(posedge aclk);
				wr(4'h4, 32'h3, 4'h1);
				cw = cw | c << 6;
				wr(4'h0, cw, 4'h3);
				sclr <= 1'b1;
				@(posedge aclk);
				sclr <= 1'b0;
				wr(4'h8, 32'h1, 4'h1);
				flag = 0;
				base = trig_seen;
				pos_level <= neg_level + 8'(1 + $urandom % 50);
				step(1);
				pos_level <= 8'h00;
				step(0);
			end
		wr(4'h4, 32'h1, 4'h1);
		repeat (3) @(posedge aclk);
		@(negedge aclk); // settled outputs only
		cmp("irq cleared", 0, irq);
		rd(4'h4);
		cmp("status w1c", 2, d);
		stop_test;
	end
endmodule : comparator_event_control_test

`default_nettype wire
